// ==== src/oms_pkg.sv ====
package oms_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_OPERATION_MODE_CHOICE = 8'h00;
   localparam logic [7:0] OFS_STARTUP_MODE_CHOICE = 8'h04;
   localparam logic [7:0] OFS_INPUT_FUNCTION_ASSIGN = 8'h08;
   localparam logic [7:0] OFS_MODE_STATUS = 8'h0C;
   localparam logic [7:0] OFS_MODE_CONTROL = 8'h10;

   // Reset values
   localparam logic [7:0] RST_OPERATION_MODE_CHOICE = 8'h00;
   localparam logic [7:0] RST_STARTUP_MODE_CHOICE = 8'h00;
   localparam logic [3:0] RST_INPUT_FUNCTION_ASSIGN = 4'h0;

   // Operation mode choice values
   localparam logic [7:0] SEL_SWITCH = 8'h00;
   localparam logic [7:0] SEL_PANEL = 8'h01;
   localparam logic [7:0] SEL_TERMINAL = 8'h02;
   localparam logic [7:0] SEL_COMBINED_A = 8'h03;
   localparam logic [7:0] SEL_COMBINED_B = 8'h04;
   localparam logic [7:0] SEL_RUN_SWITCH = 8'h06;
   localparam logic [7:0] SEL_INTERLOCK = 8'h07;

   // Startup mode choice values
   localparam logic [7:0] STM_FOLLOW = 8'h00;
   localparam logic [7:0] STM_NETWORK = 8'h01;
   localparam logic [7:0] STM_NET_PANEL = 8'h0A;

   // Input function assign field positions
   localparam int ASG_NET_PANEL = 0;
   localparam int ASG_NET_TERMINAL = 1;
   localparam int ASG_PANEL_TERMINAL = 2;
   localparam int ASG_INTERLOCK = 3;

   // Status field positions
   localparam int STS_MODE_LSB = 0;
   localparam int STS_STARTUP_PEND = 2;
   localparam int STS_SWITCH_OK = 3;
   localparam int STS_OUTPUT_STOP = 4;

   // Control field position
   localparam int CTL_RESTART = 0;

   // Operating modes
   typedef enum logic [1:0] {
      OMS_MODE_TERMINAL = 2'b00,
      OMS_MODE_PANEL = 2'b01,
      OMS_MODE_NETWORK = 2'b10,
      OMS_MODE_COMBINED = 2'b11
   } oms_mode_e;

   // Terminal switch inputs, carried together
   typedef struct packed {
      logic output_stop_input;
      logic panel_interlock_input;
      logic panel_terminal_switch_input;
      logic net_terminal_switch_input;
      logic net_panel_switch_input;
   } oms_switch_s;

endpackage

// ==== src/oms_operation_mode_selector.sv ====
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module oms_operation_mode_selector (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Terminal pins
   input wire oms_pkg::oms_switch_s switch_pins,
   // Drive state, same clock
   input wire logic motor_running,
   input wire logic start_command,
   // Mode outputs
   output oms_pkg::oms_mode_e operation_mode,
   output logic output_stop,
   output logic network_host_enable
);

   logic [7:0] sel_r;
   logic [7:0] stm_r;
   logic [3:0] asg_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic [4:0] sync3_r;
   oms_pkg::oms_switch_s flt_r;
   oms_pkg::oms_mode_e mode_r;
   oms_pkg::oms_mode_e mode_nxt;
   logic startup_pend_r;
   logic output_stop_r;
   logic net_host_r;
   logic interlock_on;
   logic switch_ok;
   logic access_first;
   logic wr_commit;
   logic addr_hit;
   logic wr_bad;
   logic [31:0] rd_mux;

   // Select values inside the accepted set
   function automatic logic sel_legal(input logic [7:0] v);
      return (v <= oms_pkg::SEL_COMBINED_B) || (v == oms_pkg::SEL_RUN_SWITCH) ||
             (v == oms_pkg::SEL_INTERLOCK);
   endfunction

   // Panel/terminal decision, or hold when unassigned
   function automatic oms_pkg::oms_mode_e panel_term(input logic asg, input logic on,
                                                     input oms_pkg::oms_mode_e cur);
      if (!asg) begin
         return cur;
      end
      return on ? oms_pkg::OMS_MODE_TERMINAL : oms_pkg::OMS_MODE_PANEL;
   endfunction

   // Mode taken at reset or restart
   function automatic oms_pkg::oms_mode_e startup_fn(input logic [7:0] sel,
                                                     input logic [7:0] stm, input logic il);
      if (sel == oms_pkg::SEL_PANEL) begin
         return oms_pkg::OMS_MODE_PANEL;
      end
      if (sel == oms_pkg::SEL_COMBINED_A || sel == oms_pkg::SEL_COMBINED_B) begin
         return oms_pkg::OMS_MODE_COMBINED;
      end
      if (stm == oms_pkg::STM_FOLLOW) begin
         return oms_pkg::OMS_MODE_TERMINAL;
      end
      if (sel == oms_pkg::SEL_INTERLOCK) begin
         // Network start only while interlock is on, and never under startup 10
         return (il && stm == oms_pkg::STM_NETWORK) ? oms_pkg::OMS_MODE_NETWORK
                                                     : oms_pkg::OMS_MODE_TERMINAL;
      end
      return oms_pkg::OMS_MODE_NETWORK;
   endfunction

   // Three-stage pin synchroniser with agreement filter
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
         sync3_r <= 5'h00;
         flt_r <= '0;
      end else begin
         sync1_r <= switch_pins;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         if (sync2_r == sync3_r) begin
            flt_r <= sync3_r;
         end
      end
   end

   // Interlock falls back to the stop pin when unassigned
   assign interlock_on = asg_r[oms_pkg::ASG_INTERLOCK] ? flt_r.panel_interlock_input
                                                        : flt_r.output_stop_input;
   // Switching allowed when stopped or start is off
   assign switch_ok = !motor_running || !start_command;

   // Target mode by fixed priority
   always_comb begin
      mode_nxt = mode_r;
      if (sel_r == oms_pkg::SEL_PANEL) begin
         mode_nxt = oms_pkg::OMS_MODE_PANEL;
      end else if (sel_r == oms_pkg::SEL_COMBINED_A || sel_r == oms_pkg::SEL_COMBINED_B) begin
         mode_nxt = oms_pkg::OMS_MODE_COMBINED;
      end else if (sel_r == oms_pkg::SEL_INTERLOCK) begin
         if (!interlock_on) begin
            mode_nxt = oms_pkg::OMS_MODE_TERMINAL;
         end else if (stm_r != oms_pkg::STM_NET_PANEL && asg_r[oms_pkg::ASG_NET_TERMINAL]
                      && flt_r.net_terminal_switch_input) begin
            mode_nxt = oms_pkg::OMS_MODE_NETWORK;
         end else begin
            mode_nxt = panel_term(asg_r[oms_pkg::ASG_PANEL_TERMINAL],
                                  flt_r.panel_terminal_switch_input, mode_r);
         end
      end else if (stm_r == oms_pkg::STM_NET_PANEL) begin
         if (sel_r == oms_pkg::SEL_TERMINAL) begin
            mode_nxt = oms_pkg::OMS_MODE_NETWORK;
         end else if (asg_r[oms_pkg::ASG_NET_TERMINAL] && flt_r.net_terminal_switch_input) begin
            mode_nxt = oms_pkg::OMS_MODE_NETWORK;
         end else if (asg_r[oms_pkg::ASG_NET_PANEL]) begin
            mode_nxt = flt_r.net_panel_switch_input ? oms_pkg::OMS_MODE_PANEL
                                                    : oms_pkg::OMS_MODE_NETWORK;
         end else if (mode_r == oms_pkg::OMS_MODE_TERMINAL) begin
            mode_nxt = oms_pkg::OMS_MODE_NETWORK;
         end
      end else if (asg_r[oms_pkg::ASG_NET_TERMINAL] && flt_r.net_terminal_switch_input) begin
         mode_nxt = oms_pkg::OMS_MODE_NETWORK;
      end else if (sel_r == oms_pkg::SEL_TERMINAL) begin
         // Panel is never offered here
         if (asg_r[oms_pkg::ASG_NET_TERMINAL] || mode_r == oms_pkg::OMS_MODE_PANEL) begin
            mode_nxt = oms_pkg::OMS_MODE_TERMINAL;
         end
      end else if (asg_r[oms_pkg::ASG_NET_PANEL]) begin
         mode_nxt = flt_r.net_panel_switch_input ? oms_pkg::OMS_MODE_PANEL
                                                 : oms_pkg::OMS_MODE_NETWORK;
      end else if (asg_r[oms_pkg::ASG_PANEL_TERMINAL]) begin
         mode_nxt = panel_term(1'b1, flt_r.panel_terminal_switch_input, mode_r);
      end else if (asg_r[oms_pkg::ASG_NET_TERMINAL]) begin
         mode_nxt = oms_pkg::OMS_MODE_TERMINAL;
      end
   end

   // Mode register; restart, select 6 and an interlock drop override a running motor
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mode_r <= oms_pkg::OMS_MODE_TERMINAL;
      end else if (startup_pend_r) begin
         mode_r <= startup_fn(sel_r, stm_r, interlock_on);
      end else if (switch_ok || sel_r == oms_pkg::SEL_RUN_SWITCH) begin
         mode_r <= mode_nxt;
      end else if (sel_r == oms_pkg::SEL_INTERLOCK && !interlock_on) begin
         mode_r <= oms_pkg::OMS_MODE_TERMINAL;
      end
   end

   // Startup evaluation after reset release or restart write
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         startup_pend_r <= 1'b1;
      end else if (wr_commit && paddr == oms_pkg::OFS_MODE_CONTROL) begin
         startup_pend_r <= pwdata[oms_pkg::CTL_RESTART];
      end else begin
         startup_pend_r <= 1'b0;
      end
   end

   // Output stop and network host permission
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         output_stop_r <= 1'b0;
         net_host_r <= 1'b0;
      end else begin
         // Stop pin keeps its own meaning unless it serves as interlock
         output_stop_r <= (sel_r == oms_pkg::SEL_INTERLOCK && interlock_on &&
                           mode_r == oms_pkg::OMS_MODE_TERMINAL) ||
                          (flt_r.output_stop_input && !(sel_r == oms_pkg::SEL_INTERLOCK &&
                           !asg_r[oms_pkg::ASG_INTERLOCK]));
         net_host_r <= (mode_r == oms_pkg::OMS_MODE_NETWORK);
      end
   end

   // APB decode; one wait state so outputs stay registered
   assign access_first = psel && penable && !pready_r;
   assign wr_commit = psel && penable && pready_r && pwrite && !pslverr_r;
   assign addr_hit = (paddr == oms_pkg::OFS_OPERATION_MODE_CHOICE) ||
                     (paddr == oms_pkg::OFS_STARTUP_MODE_CHOICE) ||
                     (paddr == oms_pkg::OFS_INPUT_FUNCTION_ASSIGN) ||
                     (paddr == oms_pkg::OFS_MODE_STATUS) ||
                     (paddr == oms_pkg::OFS_MODE_CONTROL);

   // Write refusals: running, illegal value, read-only status
   always_comb begin
      wr_bad = 1'b0;
      if (pwrite) begin
         if (motor_running && paddr != oms_pkg::OFS_MODE_CONTROL) begin
            wr_bad = 1'b1;
         end else if (paddr == oms_pkg::OFS_OPERATION_MODE_CHOICE) begin
            wr_bad = !sel_legal(pwdata[7:0]) || (pwdata[31:8] != 24'h000000);
         end else if (paddr == oms_pkg::OFS_STARTUP_MODE_CHOICE) begin
            wr_bad = !(pwdata[31:0] == {24'h000000, oms_pkg::STM_FOLLOW} ||
                       pwdata[31:0] == {24'h000000, oms_pkg::STM_NETWORK} ||
                       pwdata[31:0] == {24'h000000, oms_pkg::STM_NET_PANEL});
         end else if (paddr == oms_pkg::OFS_MODE_STATUS) begin
            wr_bad = 1'b1;
         end
      end
   end

   // Read mux
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (paddr)
         oms_pkg::OFS_OPERATION_MODE_CHOICE: rd_mux[7:0] = sel_r;
         oms_pkg::OFS_STARTUP_MODE_CHOICE: rd_mux[7:0] = stm_r;
         oms_pkg::OFS_INPUT_FUNCTION_ASSIGN: rd_mux[3:0] = asg_r;
         oms_pkg::OFS_MODE_STATUS: begin
            rd_mux[oms_pkg::STS_MODE_LSB +: 2] = mode_r;
            rd_mux[oms_pkg::STS_STARTUP_PEND] = startup_pend_r;
            rd_mux[oms_pkg::STS_SWITCH_OK] = switch_ok;
            rd_mux[oms_pkg::STS_OUTPUT_STOP] = output_stop_r;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   // APB response registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else if (access_first) begin
         pready_r <= 1'b1;
         pslverr_r <= !addr_hit || wr_bad;
         prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   // Setting registers, written at the completing edge
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sel_r <= oms_pkg::RST_OPERATION_MODE_CHOICE;
         stm_r <= oms_pkg::RST_STARTUP_MODE_CHOICE;
         asg_r <= oms_pkg::RST_INPUT_FUNCTION_ASSIGN;
      end else if (wr_commit) begin
         if (paddr == oms_pkg::OFS_OPERATION_MODE_CHOICE) begin
            sel_r <= pwdata[7:0];
         end
         if (paddr == oms_pkg::OFS_STARTUP_MODE_CHOICE) begin
            stm_r <= pwdata[7:0];
         end
         if (paddr == oms_pkg::OFS_INPUT_FUNCTION_ASSIGN) begin
            asg_r <= pwdata[3:0];
         end
      end
   end

   // Outputs straight from registers
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign operation_mode = mode_r;
   assign output_stop = output_stop_r;
   assign network_host_enable = net_host_r;

   // Checks
   a_fixed_panel: assert property (@(posedge clk_sys) disable iff (!arst_n)
      sel_r == oms_pkg::SEL_PANEL && (switch_ok || startup_pend_r)
      |=> mode_r == oms_pkg::OMS_MODE_PANEL)
      else $error("select 1 did not give panel mode");
   a_fixed_combined: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sel_r == oms_pkg::SEL_COMBINED_A || sel_r == oms_pkg::SEL_COMBINED_B) &&
      (switch_ok || startup_pend_r) |=> mode_r == oms_pkg::OMS_MODE_COMBINED)
      else $error("select 3 or 4 did not give combined mode");
   a_interlock_force: assert property (@(posedge clk_sys) disable iff (!arst_n)
      sel_r == oms_pkg::SEL_INTERLOCK && !interlock_on
      |=> mode_r == oms_pkg::OMS_MODE_TERMINAL)
      else $error("interlock off did not force terminal mode");
   a_no_terminal_s10: assert property (@(posedge clk_sys) disable iff (!arst_n)
      stm_r == oms_pkg::STM_NET_PANEL && !startup_pend_r && switch_ok &&
      (sel_r == oms_pkg::SEL_SWITCH || sel_r == oms_pkg::SEL_RUN_SWITCH)
      |=> mode_r != oms_pkg::OMS_MODE_TERMINAL)
      else $error("terminal mode entered under startup 10");
   a_no_panel_sel2: assert property (@(posedge clk_sys) disable iff (!arst_n)
      stm_r != oms_pkg::STM_NET_PANEL && sel_r == oms_pkg::SEL_TERMINAL && !startup_pend_r &&
      switch_ok |=> mode_r != oms_pkg::OMS_MODE_PANEL)
      else $error("panel mode entered with select 2");
   a_defer_running: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !switch_ok && !startup_pend_r && sel_r != oms_pkg::SEL_RUN_SWITCH &&
      !(sel_r == oms_pkg::SEL_INTERLOCK && !interlock_on) |=> $stable(mode_r))
      else $error("mode changed while running");
   a_net_terminal_on: assert property (@(posedge clk_sys) disable iff (!arst_n)
      switch_ok && !startup_pend_r && stm_r != oms_pkg::STM_NET_PANEL &&
      (sel_r == oms_pkg::SEL_SWITCH || sel_r == oms_pkg::SEL_TERMINAL) &&
      asg_r[oms_pkg::ASG_NET_TERMINAL] && flt_r.net_terminal_switch_input
      |=> mode_r == oms_pkg::OMS_MODE_NETWORK)
      else $error("net/terminal input on did not give network");
   a_net_panel_on: assert property (@(posedge clk_sys) disable iff (!arst_n)
      switch_ok && !startup_pend_r && stm_r == oms_pkg::STM_NET_PANEL &&
      sel_r == oms_pkg::SEL_SWITCH && asg_r[oms_pkg::ASG_NET_PANEL] &&
      flt_r.net_panel_switch_input &&
      !(asg_r[oms_pkg::ASG_NET_TERMINAL] && flt_r.net_terminal_switch_input)
      |=> mode_r == oms_pkg::OMS_MODE_PANEL)
      else $error("net/panel input on did not give panel");
   a_bad_select: assert property (@(posedge clk_sys) disable iff (!arst_n)
      access_first && pwrite && paddr == oms_pkg::OFS_OPERATION_MODE_CHOICE &&
      !sel_legal(pwdata[7:0]) |=> pslverr_r ##1 $stable(sel_r))
      else $error("illegal select accepted");
   a_apb_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
      access_first |=> pready_r ##1 !pready_r)
      else $error("apb answer not one wait state");

   c_run_switch: cover property (@(posedge clk_sys) disable iff (!arst_n)
      motor_running && start_command && sel_r == oms_pkg::SEL_RUN_SWITCH &&
      mode_r != mode_nxt);
   c_network_start: cover property (@(posedge clk_sys) disable iff (!arst_n)
      startup_pend_r ##1 mode_r == oms_pkg::OMS_MODE_NETWORK);
   c_interlock_stop: cover property (@(posedge clk_sys) disable iff (!arst_n)
      output_stop_r && sel_r == oms_pkg::SEL_INTERLOCK);

endmodule // oms_operation_mode_selector

// ==== test/oms_pin_model.sv ====
`timescale 1ns/1ps
module oms_pin_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Requested contact levels and settle time
   input wire oms_pkg::oms_switch_s want,
   input wire logic [3:0] settle_cycles,
   // Terminal pins toward the block
   output oms_pkg::oms_switch_s switch_pins
);
   logic [3:0] wait_r;

   // Contacts follow the request only after the settle time, so slow relays can be mimicked
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wait_r <= 4'h0;
         switch_pins <= '0;
      end else if (switch_pins == want) begin
         wait_r <= 4'h0;
      end else if (wait_r >= settle_cycles) begin
         switch_pins <= want;
         wait_r <= 4'h0;
      end else begin
         wait_r <= wait_r + 4'h1;
      end
   end
endmodule // oms_pin_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
   logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr;
   logic motor_running, start_command, err, output_stop, network_host_enable;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] settle;
   oms_pkg::oms_switch_s want, switch_pins;
   oms_pkg::oms_mode_e operation_mode;
   int fail_count, checks_done, cyc, i;

   oms_operation_mode_selector DUT (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .switch_pins(switch_pins),
      .motor_running(motor_running), .start_command(start_command),
      .operation_mode(operation_mode), .output_stop(output_stop),
      .network_host_enable(network_host_enable));

   oms_pin_model pins (.clk_sys(clk_sys), .arst_n(arst_n), .want(want),
      .settle_cycles(settle), .switch_pins(switch_pins));

   // Clock at 10 MHz
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop;
      if (fail_count == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         report_and_stop;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk(err, e);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk(err, e);
   endtask

   // Settings, input assignment, then re-run of startup selection
   task automatic cfg(input logic [7:0] sel, input logic [7:0] stm, input logic [3:0] asg);
      wr(oms_pkg::OFS_OPERATION_MODE_CHOICE, {24'h0, sel}, 1'b0);
      wr(oms_pkg::OFS_STARTUP_MODE_CHOICE, {24'h0, stm}, 1'b0);
      wr(oms_pkg::OFS_INPUT_FUNCTION_ASSIGN, {28'h0, asg}, 1'b0);
      wr(oms_pkg::OFS_MODE_CONTROL, 32'h1, 1'b0);
   endtask

   // Bounded wait covers pin sync and slow contacts; the first two edges
   // let a restart's startup value show instead of the stale mode
   task automatic wait_mode(input logic [1:0] m);
      int k;
      repeat (2) @(posedge clk_sys);
      for (k = 0; k < 40 && operation_mode !== m; k++) @(posedge clk_sys);
      chk(operation_mode, m);
   endtask

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      motor_running = 1'b0;
      start_command = 1'b0;
      want = '0;
      settle = 4'h0;
      arst_n = 1'b0;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      // Reset values and refusals
      rdchk(oms_pkg::OFS_OPERATION_MODE_CHOICE, 32'h0, 1'b0);
      rdchk(oms_pkg::OFS_STARTUP_MODE_CHOICE, 32'h0, 1'b0);
      chk(operation_mode, oms_pkg::OMS_MODE_TERMINAL);
      wr(oms_pkg::OFS_OPERATION_MODE_CHOICE, 32'h5, 1'b1);
      wr(oms_pkg::OFS_STARTUP_MODE_CHOICE, 32'h2, 1'b1);
      wr(oms_pkg::OFS_MODE_STATUS, 32'h0, 1'b1);
      rdchk(8'h14, 32'h0, 1'b1);
      rdchk(oms_pkg::OFS_OPERATION_MODE_CHOICE, 32'h0, 1'b0);
      // Start straight into network mode
      cfg(8'h00, 8'h01, 4'h0);
      wait_mode(oms_pkg::OMS_MODE_NETWORK);
      @(posedge clk_sys);
      chk(network_host_enable, 1'b1);
      // Net/terminal input with panel/terminal fallback
      want <= 5'b00010;
      cfg(8'h00, 8'h00, 4'h6);
      wait_mode(oms_pkg::OMS_MODE_NETWORK);
      want <= 5'b00000;
      wait_mode(oms_pkg::OMS_MODE_PANEL);
      @(posedge clk_sys);
      chk(network_host_enable, 1'b0);
      settle <= 4'hC;
      want <= 5'b00100;
      wait_mode(oms_pkg::OMS_MODE_TERMINAL);
      // Change held while running, applied once start is off
      motor_running <= 1'b1;
      start_command <= 1'b1;
      want <= 5'b00000;
      repeat (30) @(posedge clk_sys);
      chk(operation_mode, oms_pkg::OMS_MODE_TERMINAL);
      start_command <= 1'b0;
      wait_mode(oms_pkg::OMS_MODE_PANEL);
      motor_running <= 1'b0;
      settle <= 4'h0;
      // Select 6 switches while running
      cfg(8'h06, 8'h00, 4'h6);
      wait_mode(oms_pkg::OMS_MODE_PANEL);
      motor_running <= 1'b1;
      start_command <= 1'b1;
      want <= 5'b00010;
      wait_mode(oms_pkg::OMS_MODE_NETWORK);
      motor_running <= 1'b0;
      start_command <= 1'b0;
      // Startup 10: panel and network only
      want <= 5'b00001;
      cfg(8'h00, 8'h0A, 4'h7);
      wait_mode(oms_pkg::OMS_MODE_PANEL);
      want <= 5'b00100;
      wait_mode(oms_pkg::OMS_MODE_NETWORK);
      repeat (20) @(posedge clk_sys);
      chk(operation_mode, oms_pkg::OMS_MODE_NETWORK);
      want <= 5'b00001;
      wait_mode(oms_pkg::OMS_MODE_PANEL);
      want <= 5'b00011;
      wait_mode(oms_pkg::OMS_MODE_NETWORK);
      // Fixed selects ignore the net/panel input
      for (i = 1; i <= 4; i++) begin
         cfg(i[7:0], 8'h0A, 4'h1);
         wait_mode(i == 1 ? oms_pkg::OMS_MODE_PANEL : i == 2 ? oms_pkg::OMS_MODE_NETWORK :
            oms_pkg::OMS_MODE_COMBINED);
      end
      // Select 2 never reaches panel mode
      want <= 5'b00001;
      cfg(8'h02, 8'h00, 4'h7);
      wait_mode(oms_pkg::OMS_MODE_TERMINAL);
      want <= 5'b00011;
      wait_mode(oms_pkg::OMS_MODE_NETWORK);
      // Select 7 interlock
      want <= 5'b01010;
      cfg(8'h07, 8'h00, 4'hE);
      wait_mode(oms_pkg::OMS_MODE_NETWORK);
      want <= 5'b00010;
      wait_mode(oms_pkg::OMS_MODE_TERMINAL);
      want <= 5'b01100;
      repeat (12) @(posedge clk_sys);
      chk(operation_mode, oms_pkg::OMS_MODE_TERMINAL);
      chk(output_stop, 1'b1);
      // Startup 1 with select 7 starts in network while interlock is on
      want <= 5'b01000;
      cfg(8'h07, 8'h01, 4'h8);
      wait_mode(oms_pkg::OMS_MODE_NETWORK);
      @(posedge clk_sys);
      chk(output_stop, 1'b0);
      report_and_stop;
   end
endmodule // tb
